/* logic/tcr_idle_output.sv */
// Output pair with dead-time idle stage
`timescale 1ns/100ps
module tcr_idle_output (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Timing
   input  wire logic       tick_i,
   input  wire logic [7:0] deadtime_i,
   // Control
   input  wire logic       main_output_enable_i,
   input  wire logic       out_idle_level_i,
   input  wire logic       comp_out_idle_level_i,
   input  wire logic       active_out_i,
   input  wire logic       active_comp_i,
   // Outputs
   output logic            channel_output_o,
   output logic            channel_comp_output_o
);
   logic [7:0] wait_count;
   logic       moe_seen;

   // Dead-time count after enable falls
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_count <= 8'h00;
         moe_seen   <= 1'b0;
      end else begin
         moe_seen <= main_output_enable_i;
         if (main_output_enable_i) begin
            wait_count <= 8'h00;
         end else if (moe_seen) begin
            wait_count <= deadtime_i;
         end else if (tick_i && wait_count != 8'h00) begin
            wait_count <= wait_count - 8'h01;
         end
      end
   end

   // Idle levels after dead-time
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         channel_output_o      <= 1'b0;
         channel_comp_output_o <= 1'b0;
      end else if (main_output_enable_i) begin
         channel_output_o      <= active_out_i;
         channel_comp_output_o <= active_comp_i;
      end else if (wait_count == 8'h00 && !moe_seen) begin
         channel_output_o      <= out_idle_level_i;
         channel_comp_output_o <= comp_out_idle_level_i;
      end else begin
         channel_output_o      <= 1'b0; // Off in dead-time
         channel_comp_output_o <= 1'b0;
      end
   end
endmodule

/* logic/tcr_pkg.sv */
// Timer control constants
package tcr_pkg;
   // Register byte offsets
   localparam logic [7:0] COUNTER_CONTROL_ADDR        = 8'h00;
   localparam logic [7:0] OUTPUT_CHANNEL_CONTROL_ADDR = 8'h04;
   localparam logic [7:0] EVENT_COMMAND_ADDR          = 8'h08;
   localparam logic [7:0] RELOAD_VALUE_ADDR           = 8'h0c;
   localparam logic [7:0] PRESCALE_VALUE_ADDR         = 8'h10;
   localparam logic [7:0] COMPARE_VALUE_ADDR          = 8'h14;
   localparam logic [7:0] CHANNEL_MODE_ADDR           = 8'h18;
   localparam logic [7:0] LOCK_LEVEL_ADDR             = 8'h1c;
   localparam logic [7:0] STATUS_ADDR                 = 8'h20;
   // Counter control fields
   localparam int COUNT_ENABLE_BIT   = 0;
   localparam int UPDATE_INHIBIT_BIT = 1;
   localparam int UPDATE_SOURCE_BIT  = 2;
   localparam int SINGLE_PULSE_BIT   = 3;
   localparam int RELOAD_BUFFER_BIT  = 7;
   localparam int CLOCK_DIVIDE_LSB   = 8;
   // Output control fields
   localparam int PRELOAD_ENABLE_BIT = 0;
   localparam int UPDATE_SELECT_BIT  = 2;
   localparam int DMA_SELECT_BIT     = 3;
   localparam int OUT_IDLE_BIT       = 8;
   localparam int COMP_OUT_IDLE_BIT  = 9;
   // Writable masks
   localparam logic [15:0] COUNTER_CONTROL_MASK = 16'h038f;
   localparam logic [15:0] OUTPUT_CONTROL_MASK  = 16'h030d;
   // Event command bits
   localparam int UPDATE_GENERATE_BIT      = 0;
   localparam int COMMUTATION_GENERATE_BIT = 5;
   // Channel mode layout
   localparam int CHAN_OUT_EN_BIT  = 0;
   localparam int CHAN_COMP_EN_BIT = 1;
   localparam int CHAN_MODE_LSB    = 2;
   // Reset values
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [15:0] VALUE_RESET   = 16'h0000;
   // Clock division codes
   localparam logic [1:0] DIVIDE_BY_ONE  = 2'h0;
   localparam logic [1:0] DIVIDE_BY_TWO  = 2'h1;
   localparam logic [1:0] DIVIDE_BY_FOUR = 2'h2;
endpackage

/* logic/tcr_sample_tick.sv */
// Sampling enable pulse
`timescale 1ns/100ps
module tcr_sample_tick (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Division setting
   input  wire logic [1:0] divide_i,
   // Single-cycle enable pulse
   output logic            tick_o
);
   logic [1:0] phase;

   // Free-running phase counter
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   // Pulse every one, two or four clocks
   always_comb begin
      unique case (divide_i)
         tcr_pkg::DIVIDE_BY_ONE:  tick_o = 1'b1;
         tcr_pkg::DIVIDE_BY_TWO:  tick_o = (phase[0] == 1'b0);
         tcr_pkg::DIVIDE_BY_FOUR: tick_o = (phase == 2'h0);
         default:                 tick_o = (phase == 2'h0); // Reserved code
      endcase
   end
endmodule

/* logic/tcr_timer_control.sv */
// Timer control registers and event logic
`timescale 1ns/100ps
// What this block does
// - Two-bit divide picks sample period of one, two or four clocks.
// - Reload buffer off writes reload directly; on, goes through shadow.
// - Single-pulse mode clears count enable at next update event.
// - Source select 0: overflow, software, slave updates raise request.
// - Source select 1: only overflow raises the request.
// - Inhibit 0: each update source copies preloads into shadows.
// - Inhibit 1: no update event; shadows keep their contents.
// - Software or slave reset still reinitialises counter and prescaler.
// - Counter advances only while count enable is 1.
// - Reserved bits of both control registers read zero.
// - Comp output takes its idle level after dead-time when main enable is 0.
// - Channel output takes its idle level after dead-time when main enable is 0.
// - Idle level bits ignore writes while lock level is nonzero.
// - DMA select picks compare event or update event for channel DMA.
// - Update select: commutation command only, or also trigger rise.
// - Preload on: enable and mode bits take effect at commutation.
// - Commutation settings act on both the main and the complementary channel.
// - Commutation command bit clears itself the next cycle, acted upon or not.
// - Software update reinitialises counter, clears prescaler, updates.
module tcr_timer_control (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Register port
   input  wire logic [7:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        write_i,
   input  wire logic        read_i,
   output logic [15:0]      rdata_o,
   // Slave update and trigger
   input  wire logic        slave_update_i,
   input  wire logic        trigger_input_i,
   // Output stage control
   input  wire logic        main_output_enable_i,
   input  wire logic [7:0]  deadtime_i,
   // Events and outputs
   output logic             update_event_o,
   output logic             update_request_o,
   output logic             channel_dma_request_o,
   output logic             compare_event_o,
   output logic             commutation_event_o,
   output logic             channel_output_o,
   output logic             channel_comp_output_o,
   output logic [15:0]      count_o
);
   logic [15:0] counter_control;
   logic [15:0] output_channel_control;
   logic [15:0] reload_preload;
   logic [15:0] reload_value;
   logic [15:0] prescale_preload;
   logic [15:0] prescale_value;
   logic [15:0] compare_preload;
   logic [15:0] compare_value;
   logic [4:0]  mode_preload;
   logic [4:0]  mode_active;
   logic [1:0]  lock_level;
   logic [15:0] prescale_count;
   logic [15:0] count;
   logic        commutation_pending;
   logic        trigger_last;
   logic        update_flag;
   logic        tick;

   logic        wr_cc;
   logic        wr_oc;
   logic        wr_cmd;
   logic        update_generate;
   logic        comm_generate;
   logic        overflow;
   logic        count_step;
   logic        next_update_event;
   logic        trigger_rise;
   logic        comm_event;
   logic        reinit;
   logic        count_enable;
   logic        preload_enable;

   // Write decode
   assign wr_cc  = write_i && addr_i == tcr_pkg::COUNTER_CONTROL_ADDR;
   assign wr_oc  = write_i && addr_i == tcr_pkg::OUTPUT_CHANNEL_CONTROL_ADDR;
   assign wr_cmd = write_i && addr_i == tcr_pkg::EVENT_COMMAND_ADDR;
   assign update_generate =
      wr_cmd && wdata_i[tcr_pkg::UPDATE_GENERATE_BIT];
   assign comm_generate =
      wr_cmd && wdata_i[tcr_pkg::COMMUTATION_GENERATE_BIT];
   assign count_enable   = counter_control[tcr_pkg::COUNT_ENABLE_BIT];
   assign preload_enable =
      output_channel_control[tcr_pkg::PRELOAD_ENABLE_BIT];

   // Counter step on prescaler wrap
   assign count_step = count_enable &&
                       prescale_count == prescale_value;
   assign overflow   = count_step && count == reload_value;

   // Update event sources gated by inhibit
   assign next_update_event =
      !counter_control[tcr_pkg::UPDATE_INHIBIT_BIT] &&
      (overflow || update_generate || slave_update_i);
   // Restart even when inhibited
   assign reinit = update_generate || slave_update_i;

   // Commutation event
   assign trigger_rise = trigger_input_i && !trigger_last;
   assign comm_event   = preload_enable && (commutation_pending ||
      (output_channel_control[tcr_pkg::UPDATE_SELECT_BIT] &&
       trigger_rise));

   // Counter control
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         counter_control <= tcr_pkg::CONTROL_RESET;
      end else if (wr_cc) begin
         counter_control <= wdata_i & tcr_pkg::COUNTER_CONTROL_MASK;
      end else if (next_update_event &&
                   counter_control[tcr_pkg::SINGLE_PULSE_BIT]) begin
         counter_control[tcr_pkg::COUNT_ENABLE_BIT] <= 1'b0;
      end
   end

   // Output channel control, idle bits locked
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         output_channel_control <= tcr_pkg::CONTROL_RESET;
      end else if (wr_oc) begin
         output_channel_control[tcr_pkg::PRELOAD_ENABLE_BIT] <=
            wdata_i[tcr_pkg::PRELOAD_ENABLE_BIT];
         output_channel_control[tcr_pkg::UPDATE_SELECT_BIT] <=
            wdata_i[tcr_pkg::UPDATE_SELECT_BIT];
         output_channel_control[tcr_pkg::DMA_SELECT_BIT] <=
            wdata_i[tcr_pkg::DMA_SELECT_BIT];
         if (lock_level == 2'h0) begin
            output_channel_control[tcr_pkg::OUT_IDLE_BIT] <=
               wdata_i[tcr_pkg::OUT_IDLE_BIT];
            output_channel_control[tcr_pkg::COMP_OUT_IDLE_BIT] <=
               wdata_i[tcr_pkg::COMP_OUT_IDLE_BIT];
         end
      end
   end

   // Lock level
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lock_level <= 2'h0;
      end else if (write_i && addr_i == tcr_pkg::LOCK_LEVEL_ADDR) begin
         lock_level <= wdata_i[1:0];
      end
   end

   // Reload value: direct or buffered
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reload_preload <= tcr_pkg::VALUE_RESET;
         reload_value   <= tcr_pkg::VALUE_RESET;
      end else begin
         if (write_i && addr_i == tcr_pkg::RELOAD_VALUE_ADDR) begin
            reload_preload <= wdata_i;
         end
         if (write_i && addr_i == tcr_pkg::RELOAD_VALUE_ADDR &&
             !counter_control[tcr_pkg::RELOAD_BUFFER_BIT]) begin
            reload_value <= wdata_i;
         end else if (next_update_event &&
                      counter_control[tcr_pkg::RELOAD_BUFFER_BIT]) begin
            reload_value <= reload_preload;
         end
      end
   end

   // Shadows load on update only
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prescale_preload <= tcr_pkg::VALUE_RESET;
         prescale_value   <= tcr_pkg::VALUE_RESET;
         compare_preload  <= tcr_pkg::VALUE_RESET;
         compare_value    <= tcr_pkg::VALUE_RESET;
      end else begin
         if (write_i && addr_i == tcr_pkg::PRESCALE_VALUE_ADDR) begin
            prescale_preload <= wdata_i;
         end
         if (write_i && addr_i == tcr_pkg::COMPARE_VALUE_ADDR) begin
            compare_preload <= wdata_i;
         end
         if (next_update_event) begin
            prescale_value <= prescale_preload;
            compare_value  <= compare_preload;
         end
      end
   end

   // Prescaler and counter
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prescale_count <= 16'h0000;
         count          <= 16'h0000;
      end else if (reinit) begin
         prescale_count <= 16'h0000;
         count          <= 16'h0000;
      end else if (count_enable) begin
         if (count_step) begin
            prescale_count <= 16'h0000;
            count <= overflow ? 16'h0000 : count + 16'h0001;
         end else begin
            prescale_count <= prescale_count + 16'h0001;
         end
      end
   end

   // Channel bits, preloaded or direct
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_preload <= 5'h00;
         mode_active  <= 5'h00;
      end else begin
         if (write_i && addr_i == tcr_pkg::CHANNEL_MODE_ADDR) begin
            mode_preload <= wdata_i[4:0];
         end
         if (!preload_enable &&
             write_i && addr_i == tcr_pkg::CHANNEL_MODE_ADDR) begin
            mode_active <= wdata_i[4:0];
         end else if (comm_event) begin
            mode_active <= mode_preload;
         end
      end
   end

   // Self-clearing commutation command
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         commutation_pending <= 1'b0;
         trigger_last        <= 1'b0;
      end else begin
         trigger_last <= trigger_input_i;
         if (comm_generate) begin
            commutation_pending <= 1'b1; // Set wins over clear
         end else begin
            commutation_pending <= 1'b0;
         end
      end
   end

   // Update flag, write zero clears, set wins
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         update_flag <= 1'b0;
      end else if (next_update_event) begin
         update_flag <= 1'b1;
      end else if (write_i && addr_i == tcr_pkg::STATUS_ADDR &&
                   !wdata_i[0]) begin
         update_flag <= 1'b0;
      end
   end

   // Event outputs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         update_event_o        <= 1'b0;
         update_request_o      <= 1'b0;
         channel_dma_request_o <= 1'b0;
         compare_event_o       <= 1'b0;
         commutation_event_o   <= 1'b0;
      end else begin
         update_event_o   <= next_update_event;
         update_request_o <= next_update_event &&
            (!counter_control[tcr_pkg::UPDATE_SOURCE_BIT] || overflow);
         compare_event_o  <= count_step && count == compare_value;
         channel_dma_request_o <=
            output_channel_control[tcr_pkg::DMA_SELECT_BIT] ?
            next_update_event : (count_step && count == compare_value);
         commutation_event_o <= comm_event;
      end
   end

   // Read data, next cycle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
      end else if (read_i) begin
         unique case (addr_i)
            tcr_pkg::COUNTER_CONTROL_ADDR:        rdata_o <= counter_control;
            tcr_pkg::OUTPUT_CHANNEL_CONTROL_ADDR:
               rdata_o <= output_channel_control;
            tcr_pkg::RELOAD_VALUE_ADDR:   rdata_o <= reload_preload;
            tcr_pkg::PRESCALE_VALUE_ADDR: rdata_o <= prescale_preload;
            tcr_pkg::COMPARE_VALUE_ADDR:  rdata_o <= compare_preload;
            tcr_pkg::CHANNEL_MODE_ADDR:   rdata_o <= {11'h000, mode_active};
            tcr_pkg::LOCK_LEVEL_ADDR:     rdata_o <= {14'h0000, lock_level};
            tcr_pkg::STATUS_ADDR:         rdata_o <= {15'h0000, update_flag};
            default:                      rdata_o <= 16'h0000;
         endcase
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   assign count_o = count;

   // Sampling enable pulse
   tcr_sample_tick u_tick (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .divide_i (counter_control[tcr_pkg::CLOCK_DIVIDE_LSB +: 2]),
      .tick_o   (tick)
   );

   // Output stage
   tcr_idle_output u_out (
      .clk_i                 (clk_i),
      .rst_i                 (rst_i),
      .tick_i                (tick),
      .deadtime_i            (deadtime_i),
      .main_output_enable_i  (main_output_enable_i),
      .out_idle_level_i      (output_channel_control[tcr_pkg::OUT_IDLE_BIT]),
      .comp_out_idle_level_i (
         output_channel_control[tcr_pkg::COMP_OUT_IDLE_BIT]),
      .active_out_i          (mode_active[tcr_pkg::CHAN_OUT_EN_BIT] &&
                              count < compare_value),
      .active_comp_i         (mode_active[tcr_pkg::CHAN_COMP_EN_BIT] &&
                              !(count < compare_value)),
      .channel_output_o      (channel_output_o),
      .channel_comp_output_o (channel_comp_output_o)
   );
endmodule

/* tb/tcr_timer_control_assertions.sv */
// Timer control assertion checker
`timescale 1ns/100ps
module tcr_timer_control_assertions (
   // Clock, reset, bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        write_i,
   input wire logic        read_i,
   input wire logic [15:0] rdata_o,
   // Side inputs
   input wire logic        slave_update_i,
   input wire logic        main_output_enable_i,
   input wire logic [7:0]  deadtime_i,
   // Outputs
   input wire logic        update_event_o,
   input wire logic        update_request_o,
   input wire logic        channel_dma_request_o,
   input wire logic        commutation_event_o,
   input wire logic        channel_output_o,
   input wire logic        channel_comp_output_o,
   input wire logic [15:0] count_o
);
   logic        inhibit_q;
   logic        source_q;
   logic        dma_q;
   logic        lock_q;
   logic [1:0]  idle_q;
   logic [10:0] low_cnt;
   logic        wr_ug;
   logic        wr_oc;

   // Decoded writes
   assign wr_ug = write_i && addr_i == 8'h08 && wdata_i[0];
   assign wr_oc = write_i && addr_i == 8'h04;

   // Mirrored control bits
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         inhibit_q <= 1'b0;
         source_q  <= 1'b0;
         dma_q     <= 1'b0;
         lock_q    <= 1'b0;
         idle_q    <= 2'h0;
      end else begin
         if (write_i && addr_i == 8'h00) begin
            inhibit_q <= wdata_i[1];
            source_q  <= wdata_i[2];
         end
         if (wr_oc) begin
            dma_q <= wdata_i[3];
         end
         if (wr_oc && !lock_q) begin
            idle_q <= wdata_i[9:8];
         end
         if (write_i && addr_i == 8'h1c) begin
            lock_q <= |wdata_i[1:0];
         end
      end
   end

   // Cycles with outputs off
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         low_cnt <= 11'h000;
      end else if (main_output_enable_i || wr_oc) begin
         low_cnt <= 11'h000;
      end else if (low_cnt != 11'h7ff) begin
         low_cnt <= low_cnt + 11'h001;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_ug_event: assert property (
      wr_ug && !inhibit_q |=> update_event_o)
      else $error("no update after command");
   chk_inhibit_quiet: assert property (
      $past(inhibit_q) && inhibit_q |-> !update_event_o)
      else $error("update while inhibited");
   chk_ug_count_clear: assert property (
      wr_ug |=> count_o == 16'h0000)
      else $error("counter not cleared");
   chk_source_any: assert property (
      update_event_o && !$past(source_q) |-> update_request_o)
      else $error("no request");
   chk_source_only: assert property (
      $past(source_q) && ($past(wr_ug) || $past(slave_update_i))
      |-> !update_request_o)
      else $error("filtered source requested");
   chk_dma_on_update: assert property (
      update_event_o && dma_q && $past(dma_q)
      |-> ##[0:1] channel_dma_request_o)
      else $error("dma missing on update");
   chk_comm_pulse: assert property (
      commutation_event_o |=> !commutation_event_o)
      else $error("commutation held");
   chk_reserved_zero: assert property (
      $past(read_i) && $past(addr_i[7:3]) == 5'h00
      |-> (rdata_o & 16'hfc70) == 16'h0000)
      else $error("reserved bits nonzero");
   chk_idle_levels: assert property (
      low_cnt > {1'b0, deadtime_i, 2'h0} + 11'h008
      |-> channel_output_o == idle_q[0]
          && channel_comp_output_o == idle_q[1])
      else $error("outputs not idle");

   cov_request: cover property (update_event_o && update_request_o);
   cov_commutation: cover property (commutation_event_o);
   cov_channel_dma: cover property (channel_dma_request_o);
endmodule

bind tcr_timer_control tcr_timer_control_assertions chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
   .slave_update_i(slave_update_i), .deadtime_i(deadtime_i),
   .main_output_enable_i(main_output_enable_i),
   .update_event_o(update_event_o), .update_request_o(update_request_o),
   .channel_dma_request_o(channel_dma_request_o),
   .commutation_event_o(commutation_event_o),
   .channel_output_o(channel_output_o),
   .channel_comp_output_o(channel_comp_output_o), .count_o(count_o)
);

/* tb/tcr_timer_control_tb.sv */
// Timer control testbench
`timescale 1ns/100ps
module tcr_timer_control_tb;
   // Bench signals
   logic        clk_i, rst_i, write_i, read_i, slave_update_i;
   logic        trigger_input_i, main_output_enable_i, seen;
   logic [7:0]  addr_i, deadtime_i;
   logic [15:0] wdata_i, rdata_o, count_o, held;
   logic        update_event_o, update_request_o, channel_dma_request_o;
   logic        compare_event_o, commutation_event_o;
   logic        channel_output_o, channel_comp_output_o;
   int          fails = 0, tests_run = 0;

   tcr_timer_control dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
      .slave_update_i(slave_update_i), .trigger_input_i(trigger_input_i),
      .main_output_enable_i(main_output_enable_i),
      .deadtime_i(deadtime_i), .update_event_o(update_event_o),
      .update_request_o(update_request_o),
      .channel_dma_request_o(channel_dma_request_o),
      .compare_event_o(compare_event_o),
      .commutation_event_o(commutation_event_o),
      .channel_output_o(channel_output_o),
      .channel_comp_output_o(channel_comp_output_o), .count_o(count_o)
   );

   // Clock generator
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Compare and report
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp);
      check({15'h0000, got}, {15'h0000, exp});
   endtask

   // Wait n edges
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // Register write
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      write_i <= 1'b1;
      @(posedge clk_i);
      write_i <= 1'b0;
      #1;
   endtask

   // Register read, data checked next cycle
   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      read_i <= 1'b1;
      @(posedge clk_i);
      read_i <= 1'b0;
      #1;
      check(rdata_o, exp);
   endtask

   // Bounded wait for an event
   task automatic wait_ev(input logic comm, input int lim);
      seen = 1'b0;
      for (int i = 0; i < lim && seen !== 1'b1; i++) begin
         tick(1);
         seen = comm ? commutation_event_o : update_event_o;
      end
   endtask

   task automatic drive_trig(input logic v);
      @(posedge clk_i);
      trigger_input_i <= v;
   endtask

   task automatic t_regs();
      rdchk(8'h00, 16'h0000);
      rdchk(8'h04, 16'h0000);
      for (int c = 0; c < 3; c++) begin
         wr(8'h00, {6'h3f, 2'(c), 8'hf2});
         rdchk(8'h00, {6'h00, 2'(c), 8'h82});
      end
      wr(8'h04, 16'hffff);
      rdchk(8'h04, 16'h030d);
      wr(8'h40, 16'hffff);
      rdchk(8'h40, 16'h0000);
      wr(8'h04, 16'h0000);
      wr(8'h00, 16'h0000);
      $display("t_regs done");
   endtask

   task automatic t_update();
      for (int s = 0; s < 2; s++) begin
         wr(8'h00, {13'h0000, s[0], 2'h0});
         wr(8'h08, 16'h0001);
         chkb(update_event_o, 1'b1);
         chkb(update_request_o, !s[0]);
         check(count_o, 16'h0000);
         @(posedge clk_i);
         slave_update_i <= 1'b1;
         @(posedge clk_i);
         slave_update_i <= 1'b0;
         #1;
         chkb(update_event_o, 1'b1);
         chkb(update_request_o, !s[0]);
      end
      wr(8'h0c, 16'h0003);
      wr(8'h00, 16'h0005);
      wait_ev(1'b0, 20);
      chkb(seen, 1'b1);
      chkb(update_request_o, 1'b1);
      wr(8'h00, 16'h0000);
      $display("t_update done");
   endtask

   task automatic t_inhibit();
      wr(8'h0c, 16'h00ff);
      wr(8'h00, 16'h0083);
      wr(8'h0c, 16'h0010);
      wr(8'h08, 16'h0001);
      chkb(update_event_o, 1'b0);
      check(count_o, 16'h0000);
      tick(24);
      chkb(count_o > 16'h0010, 1'b1);
      wr(8'h00, 16'h0081);
      wr(8'h08, 16'h0001);
      chkb(update_event_o, 1'b1);
      wait_ev(1'b0, 40);
      chkb(seen, 1'b1);
      wr(8'h00, 16'h0000);
      held = count_o;
      tick(4);
      check(count_o, held);
      $display("t_inhibit done");
   endtask

   task automatic t_single();
      wr(8'h14, 16'h0002);
      wr(8'h08, 16'h0001);
      wr(8'h0c, 16'h0003);
      wr(8'h00, 16'h0009);
      tick(3);
      chkb(compare_event_o, 1'b1);
      chkb(channel_dma_request_o, 1'b1);
      wait_ev(1'b0, 20);
      chkb(seen, 1'b1);
      rdchk(8'h00, 16'h0008);
      held = count_o;
      tick(4);
      check(count_o, held);
      $display("t_single done");
   endtask

   task automatic t_dma();
      wr(8'h14, 16'h00ff);
      for (int d = 0; d < 2; d++) begin
         wr(8'h04, {12'h000, d[0], 3'h0});
         wr(8'h08, 16'h0001);
         held[0] = channel_dma_request_o;
         tick(1);
         held[1] = channel_dma_request_o;
         chkb(|held[1:0], d[0]);
      end
      $display("t_dma done");
   endtask

   task automatic t_idle();
      wr(8'h00, 16'h0200);
      wr(8'h04, 16'h0300);
      @(posedge clk_i);
      main_output_enable_i <= 1'b1;
      tick(8);
      @(posedge clk_i);
      main_output_enable_i <= 1'b0;
      tick(2);
      chkb(channel_comp_output_o, 1'b0);
      tick(60);
      chkb(channel_output_o, 1'b1);
      chkb(channel_comp_output_o, 1'b1);
      wr(8'h00, 16'h0000);
      $display("t_idle done");
   endtask

   task automatic t_comm();
      wr(8'h04, 16'h0301);
      wr(8'h18, 16'h0003);
      rdchk(8'h18, 16'h0000);
      wr(8'h08, 16'h0020);
      wait_ev(1'b1, 4);
      chkb(seen, 1'b1);
      rdchk(8'h18, 16'h0003);
      wr(8'h18, 16'h0001);
      drive_trig(1'b1);
      wait_ev(1'b1, 4);
      chkb(seen, 1'b0);
      drive_trig(1'b0);
      wr(8'h04, 16'h0305);
      drive_trig(1'b1);
      wait_ev(1'b1, 4);
      chkb(seen, 1'b1);
      drive_trig(1'b0);
      rdchk(8'h18, 16'h0001);
      wr(8'h04, 16'h0300);
      wr(8'h18, 16'h0014);
      rdchk(8'h18, 16'h0014);
      wr(8'h1c, 16'h0001);
      wr(8'h04, 16'h0008);
      rdchk(8'h04, 16'h0308);
      $display("t_comm done");
   endtask

   // Verdict
   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (5000) @(posedge clk_i);
      fails++;
      $display("BAD %0t watchdog expired", $time);
      finish_test();
   end

   // Main sequence
   initial begin
      rst_i = 1'b1;
      addr_i = 8'h00;
      wdata_i = 16'h0000;
      write_i = 1'b0;
      read_i = 1'b0;
      slave_update_i = 1'b0;
      trigger_input_i = 1'b0;
      main_output_enable_i = 1'b0;
      deadtime_i = 8'h08;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_update();
      t_inhibit();
      t_single();
      t_dma();
      t_idle();
      t_comm();
      finish_test();
   end
endmodule
